// ==== design/parameter_register_access.sv ====
// Command interpreter giving a terminal access to a bank of numbered parameter registers.
// Assumes one character per rxValid pulse, a tx sink with ready, and memory that keeps
// the profile arrays while arst_n is low (they carry no reset).
//
// Notes on behaviour
// [R1] There are 28 numbered registers: 22 configuration, one installation, five unused.
// [R2] Eleven registers are storable and their stored values are restored at power-up.
// [R3] Two stored profiles of the storable registers exist beside the active set.
// [R4] After power-up the last saved values are active until a command changes them; the code loads the profile picked by &Y.
// [R5] A query returns the register value as exactly three decimal digits, then OK.
// [R6] A write with a register number and a value stores the value, then answers OK.
// [R7] Register numbers one to nine are accepted with or without a leading zero.
// [R8] Values are entered with one to three digits but always shown with three.
// [R9] The full display shows bit-mapped registers as two hex digits and an H.
// [R10] Some commands change only a bit group of a bit-mapped register.
// [R11] Saving a profile writes only the storable registers.
// [R12] Changes to non-storable registers are lost when power goes.
// [R13] A startup selection command picks which profile is loaded at power-up.
// [R14] The display command shows the active set and both profiles, then OK.
// [R15] Character-code registers hold and report the character's decimal code.
// [R16] The terminator register's character ends command lines and follows every result.
// [R17] A bad or unused register number changes nothing and gives an error result.
`timescale 1ns/1ps
`include "param_access_regs.svh"

module parameter_register_access
   import param_access_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Characters from the terminal.
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   // Characters to the terminal.
   output logic [7:0] txData,
   output logic txValid,
   input wire logic txReady,
   // High while the profile memory is blank and must take factory values.
   input wire logic nvFactory
);

   // Factory value of one register.
   function automatic char_t defaultOf(input logic [4:0] i);
      logic [223:0] tbl;
      tbl = `DEF_TABLE;
      return tbl[{i, 3'h0} +: 8];
   endfunction

   function automatic logic isDigit(input char_t c);
      return (c >= `CH_0) && (c <= `CH_9);
   endfunction

   function automatic logic [3:0] digitOf(input char_t c);
      return c[3:0];
   endfunction

   // Masks held as named vectors, because a bit cannot be selected from a bare literal.
   localparam logic [27:0] USED_REGS = `USED_MASK;
   localparam logic [27:0] STORE_REGS = `STORE_MASK;
   localparam logic [27:0] HEX_REGS = `HEX_MASK;

   state_t state_r, state_nxt;
   state_t after_r, after_nxt;
   char_t lineBuf_r [0:7];
   char_t lineBuf_nxt [0:7];
   logic [3:0] lineLen_r, lineLen_nxt;
   logic ovf_r, ovf_nxt;
   char_t regs_r [0:27];
   char_t regs_nxt [0:27];
   char_t prof0_r [0:27];
   char_t prof0_nxt [0:27];
   char_t prof1_r [0:27];
   char_t prof1_nxt [0:27];
   logic startSel_r, startSel_nxt;
   char_t msg_r [0:7];
   char_t msg_nxt [0:7];
   logic [3:0] msgLen_r, msgLen_nxt;
   logic [3:0] msgPos_r, msgPos_nxt;
   logic okFlag_r, okFlag_nxt;
   logic [1:0] sec_r, sec_nxt;
   logic [4:0] idx_r, idx_nxt;
   char_t txData_r, txData_nxt;
   logic txValid_r, txValid_nxt;

   // Parsed view of the collected line.
   logic [6:0] pNum;
   logic [3:0] pOpPos;
   char_t pOp;
   logic [9:0] pVal;
   logic [3:0] pCnt;
   logic pBad;
   logic pRegOk;
   logic [3:0] argD;
   logic argOk;
   char_t dumpVal;
   char_t fmtValue;
   logic fmtHex;
   char_t f0, f1, f2;
   char_t term;
   logic [4:0] numIdx;

   assign term = regs_r[`TERM_IDX]; // [R16]
   assign numIdx = pNum[4:0];

   // Line parser: register number of one or two digits, operator, value of one to three.
   always_comb begin
      if (isDigit(lineBuf_r[2])) begin
         pNum = 7'(digitOf(lineBuf_r[1])) * 7'h0A + 7'(digitOf(lineBuf_r[2])); // [R7]
         pOpPos = 4'h3;
      end else begin
         pNum = 7'(digitOf(lineBuf_r[1])); // [R7]
         pOpPos = 4'h2;
      end
      pOp = lineBuf_r[pOpPos[2:0]];
      pVal = 10'h000;
      pCnt = 4'h0;
      pBad = 1'b0;
      for (int k = 0; k < 8; k++) begin
         if ((4'(k) > pOpPos) && (4'(k) < lineLen_r)) begin
            if (isDigit(lineBuf_r[k])) begin
               pVal = 10'(pVal * 10'h00A) + 10'(digitOf(lineBuf_r[k])); // [R8] [R15]
               pCnt = pCnt + 4'h1;
            end else begin
               pBad = 1'b1;
            end
         end
      end
      // Unused and out-of-range numbers are refused.
      pRegOk = isDigit(lineBuf_r[1]) && (pNum < 7'(`REG_COUNT)) && USED_REGS[numIdx]; // [R17]
      argD = digitOf(lineBuf_r[2]);
      argOk = (lineLen_r == 4'h3) && isDigit(lineBuf_r[2]);
   end

   // Display value: the active set, then each profile.
   always_comb begin
      dumpVal = 8'h00;
      if (idx_r <= 5'(`REG_LAST)) begin
         unique case (sec_r)
            2'h0: dumpVal = regs_r[idx_r];
            2'h1: dumpVal = prof0_r[idx_r];
            default: dumpVal = prof1_r[idx_r];
         endcase
      end
      fmtValue = (state_r == ST_DUMP) ? dumpVal : regs_r[numIdx];
      fmtHex = (state_r == ST_DUMP) && (idx_r <= 5'(`REG_LAST)) && HEX_REGS[idx_r]; // [R9]
   end

   value_formatter fmt (
      .value(fmtValue),
      .hexMode(fmtHex),
      .char0(f0),
      .char1(f1),
      .char2(f2)
   );

   // Interpreter next state: receive a line, execute it, send the reply.
   always_comb begin
      state_nxt = state_r;
      after_nxt = after_r;
      lineBuf_nxt = lineBuf_r;
      lineLen_nxt = lineLen_r;
      ovf_nxt = ovf_r;
      regs_nxt = regs_r;
      prof0_nxt = prof0_r;
      prof1_nxt = prof1_r;
      startSel_nxt = startSel_r;
      msg_nxt = msg_r;
      msgLen_nxt = msgLen_r;
      msgPos_nxt = msgPos_r;
      okFlag_nxt = okFlag_r;
      sec_nxt = sec_r;
      idx_nxt = idx_r;
      txData_nxt = txData_r;
      txValid_nxt = txValid_r;
      unique case (state_r)
         ST_LOAD: begin
            // Storable registers come back from the chosen profile; a blank memory
            // is filled with factory values first.
            for (int i = 0; i <= `REG_LAST; i++) begin
               if (STORE_REGS[i]) begin
                  if (nvFactory) begin
                     prof0_nxt[i] = defaultOf(5'(i));
                     prof1_nxt[i] = defaultOf(5'(i));
                     regs_nxt[i] = defaultOf(5'(i));
                  end else begin
                     regs_nxt[i] = startSel_r ? prof1_r[i] : prof0_r[i]; // [R2] [R4] [R13]
                  end
               end
            end
            if (nvFactory) begin
               startSel_nxt = 1'b0;
            end
            state_nxt = ST_IDLE;
         end
         ST_IDLE: begin
            if (rxValid && ((rxData == `CH_A) || (rxData == `CH_LA))) begin
               state_nxt = ST_GOT_A;
            end
         end
         ST_GOT_A: begin
            if (rxValid) begin
               if ((rxData == `CH_T) || (rxData == `CH_LT)) begin
                  state_nxt = ST_COLLECT;
                  lineLen_nxt = 4'h0;
                  ovf_nxt = 1'b0;
                  lineBuf_nxt = '{default: 8'h00};
               end else if ((rxData != `CH_A) && (rxData != `CH_LA)) begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_COLLECT: begin
            // Spaces are dropped; anything past the line buffer marks the line bad.
            if (rxValid) begin
               if (rxData == term) begin
                  state_nxt = ST_EXEC; // [R16]
               end else if (rxData != `CH_SPACE) begin
                  if (lineLen_r < `LINE_DEPTH) begin
                     lineBuf_nxt[lineLen_r[2:0]] = rxData;
                     lineLen_nxt = lineLen_r + 4'h1;
                  end else begin
                     ovf_nxt = 1'b1;
                  end
               end
            end
         end
         ST_EXEC: begin
            okFlag_nxt = 1'b0;
            state_nxt = ST_RESULT;
            if (ovf_r) begin
               okFlag_nxt = 1'b0;
            end else if (lineLen_r == 4'h0) begin
               okFlag_nxt = 1'b1;
            end else if ((lineBuf_r[0] == `CH_S) || (lineBuf_r[0] == `CH_LS)) begin
               if (pRegOk && (pOp == `CH_QUERY) && (lineLen_r == pOpPos + 4'h1)) begin
                  msg_nxt[0] = f0; // [R5]
                  msg_nxt[1] = f1;
                  msg_nxt[2] = f2;
                  msg_nxt[3] = term;
                  msgLen_nxt = 4'h4;
                  msgPos_nxt = 4'h0;
                  okFlag_nxt = 1'b1;
                  after_nxt = ST_RESULT;
                  state_nxt = ST_SEND;
               end else if (pRegOk && (pOp == `CH_EQ) && !pBad && (pCnt != 4'h0) &&
                            (pCnt <= 4'h3) && (pVal <= `VALUE_MAX)) begin
                  regs_nxt[numIdx] = pVal[7:0]; // [R6] [R12]
                  okFlag_nxt = 1'b1;
               end
            end else if (lineBuf_r[0] == `CH_AMP) begin
               if ((lineBuf_r[1] == `CH_V) && (lineLen_r == 4'h2)) begin
                  sec_nxt = 2'h0; // [R14]
                  idx_nxt = 5'h00;
                  state_nxt = ST_DUMP;
               end else if ((lineBuf_r[1] == `CH_W) && argOk && (argD <= `PROFILE_MAX)) begin
                  for (int i = 0; i <= `REG_LAST; i++) begin
                     if (STORE_REGS[i]) begin // [R11] [R3]
                        if (argD[0]) begin
                           prof1_nxt[i] = regs_r[i];
                        end else begin
                           prof0_nxt[i] = regs_r[i];
                        end
                     end
                  end
                  okFlag_nxt = 1'b1;
               end else if ((lineBuf_r[1] == `CH_Y) && argOk && (argD <= `PROFILE_MAX)) begin
                  startSel_nxt = argD[0]; // [R13]
                  okFlag_nxt = 1'b1;
               end else if ((lineBuf_r[1] == `CH_D) && argOk && (argD <= `DCD_MAX)) begin
                  regs_nxt[`DCD_IDX][`DCD_LSB +: 2] = argD[1:0]; // [R10]
                  okFlag_nxt = 1'b1;
               end
            end
         end
         ST_DUMP: begin
            // One entry per pass; a terminator closes each of the three sections.
            msgPos_nxt = 4'h0;
            if (sec_r == 2'h3) begin
               okFlag_nxt = 1'b1;
               state_nxt = ST_RESULT;
            end else if (idx_r > 5'(`REG_LAST)) begin
               msg_nxt[0] = term;
               msgLen_nxt = 4'h1;
               sec_nxt = sec_r + 2'h1;
               idx_nxt = 5'h00;
               after_nxt = ST_DUMP;
               state_nxt = ST_SEND;
            end else begin
               idx_nxt = idx_r + 5'h01;
               if ((sec_r == 2'h0) ? USED_REGS[idx_r] : STORE_REGS[idx_r]) begin // [R1]
                  msg_nxt[0] = `CH_S;
                  msg_nxt[1] = (idx_r >= 5'h14) ? 8'h32 : ((idx_r >= 5'h0A) ? 8'h31 : `CH_0);
                  msg_nxt[2] = {3'h0, idx_r % 5'h0A} + `CH_0;
                  msg_nxt[3] = `CH_COLON;
                  msg_nxt[4] = f0; // [R8] [R9]
                  msg_nxt[5] = f1;
                  msg_nxt[6] = f2;
                  msg_nxt[7] = `CH_SPACE;
                  msgLen_nxt = 4'h8;
                  after_nxt = ST_DUMP;
                  state_nxt = ST_SEND;
               end
            end
         end
         ST_RESULT: begin
            // The result word is always followed by the terminator character.
            msgPos_nxt = 4'h0;
            after_nxt = ST_IDLE;
            state_nxt = ST_SEND;
            if (okFlag_r) begin
               msg_nxt[0] = `CH_O;
               msg_nxt[1] = `CH_K;
               msg_nxt[2] = term; // [R16]
               msgLen_nxt = 4'h3;
            end else begin
               msg_nxt[0] = `CH_E; // [R17]
               msg_nxt[1] = `CH_R;
               msg_nxt[2] = `CH_R;
               msg_nxt[3] = `CH_O;
               msg_nxt[4] = `CH_R;
               msg_nxt[5] = term;
               msgLen_nxt = 4'h6;
            end
         end
         ST_SEND: begin
            // Characters arriving while a reply is sent are ignored; no input buffer.
            if (!txValid_r || txReady) begin
               if (msgPos_r < msgLen_r) begin
                  txData_nxt = msg_r[msgPos_r[2:0]];
                  txValid_nxt = 1'b1;
                  msgPos_nxt = msgPos_r + 4'h1;
               end else begin
                  txValid_nxt = 1'b0;
                  state_nxt = after_r;
               end
            end
         end
      endcase
   end

   // Volatile state takes factory values on reset, which is the power-loss case.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_LOAD;
         after_r <= ST_IDLE;
         lineBuf_r <= '{default: 8'h00};
         lineLen_r <= 4'h0;
         ovf_r <= 1'b0;
         for (int i = 0; i <= `REG_LAST; i++) begin
            regs_r[i] <= defaultOf(5'(i)); // [R12]
         end
         msg_r <= '{default: 8'h00};
         msgLen_r <= 4'h0;
         msgPos_r <= 4'h0;
         okFlag_r <= 1'b0;
         sec_r <= 2'h0;
         idx_r <= 5'h00;
         txData_r <= 8'h00;
         txValid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         after_r <= after_nxt;
         lineBuf_r <= lineBuf_nxt;
         lineLen_r <= lineLen_nxt;
         ovf_r <= ovf_nxt;
         regs_r <= regs_nxt;
         msg_r <= msg_nxt;
         msgLen_r <= msgLen_nxt;
         msgPos_r <= msgPos_nxt;
         okFlag_r <= okFlag_nxt;
         sec_r <= sec_nxt;
         idx_r <= idx_nxt;
         txData_r <= txData_nxt;
         txValid_r <= txValid_nxt;
      end
   end

   // Profile memory and startup choice model nonvolatile storage, so they have no reset.
   always_ff @(posedge clk) begin
      prof0_r <= prof0_nxt; // [R3]
      prof1_r <= prof1_nxt;
      startSel_r <= startSel_nxt;
   end

   assign txData = txData_r;
   assign txValid = txValid_r;

endmodule

// ==== include/param_access_regs.svh ====
// Constants for the parameter register command interpreter.
// Assumes 8-bit text characters and one register bank of eight-bit values.
`ifndef PARAM_ACCESS_REGS_SVH
`define PARAM_ACCESS_REGS_SVH

// Register bank shape.
`define REG_COUNT 5'h1C
`define REG_LAST 27
`define LINE_DEPTH 4'h8
// One bit per register index: implemented, storable, shown in hex.
`define USED_MASK 28'hFF5_57FF
`define STORE_MASK 28'hFF4_4001
`define HEX_MASK 28'h9E1_4000
// Factory values, one byte per index, index 27 in the top byte.
`define DEF_TABLE 224'h4001_0500_0B46_0000_0000_0000_00AA_0032_000E_0602_3C02_080A_0D2B_0000
// Special registers and the bit group set by the carrier-detect command.
`define TERM_IDX 5'h03
`define DCD_IDX 5'h15
`define DCD_LSB 3
`define DCD_MAX 4'h3
`define PROFILE_MAX 4'h1
`define VALUE_MAX 10'h0FF
// Characters.
`define CH_0 8'h30
`define CH_9 8'h39
`define CH_A 8'h41
`define CH_LA 8'h61
`define CH_T 8'h54
`define CH_LT 8'h74
`define CH_S 8'h53
`define CH_LS 8'h73
`define CH_AMP 8'h26
`define CH_QUERY 8'h3F
`define CH_EQ 8'h3D
`define CH_COLON 8'h3A
`define CH_SPACE 8'h20
`define CH_W 8'h57
`define CH_Y 8'h59
`define CH_V 8'h56
`define CH_D 8'h44
`define CH_O 8'h4F
`define CH_K 8'h4B
`define CH_E 8'h45
`define CH_R 8'h52
`define CH_H 8'h48

`endif

// ==== include/param_access_pkg.sv ====
// Types shared by the parameter register command interpreter.
// Assumes nothing of its surroundings.
package param_access_pkg;

   // Interpreter sequence states.
   typedef enum logic [3:0] {
      ST_LOAD,
      ST_IDLE,
      ST_GOT_A,
      ST_COLLECT,
      ST_EXEC,
      ST_SEND,
      ST_DUMP,
      ST_RESULT
   } state_t;

   typedef logic [7:0] char_t;

endpackage

// ==== design/value_formatter.sv ====
// Turns one register value into three display characters.
// Assumes the caller picks decimal or hexadecimal and reads the result in the same cycle.
`timescale 1ns/1ps
`include "param_access_regs.svh"

module value_formatter
   import param_access_pkg::*;
(
   // Value and display mode.
   input wire logic [7:0] value,
   input wire logic hexMode,
   // Three characters, leftmost first.
   output char_t char0,
   output char_t char1,
   output char_t char2
);

   // Hex nibble to an uppercase character.
   function automatic char_t hexChar(input logic [3:0] n);
      if (n > 4'h9) begin
         return 8'(n - 4'hA) + `CH_A;
      end
      return {4'h0, n} + `CH_0;
   endfunction

   logic [7:0] hundreds;
   logic [7:0] rest;

   // Decimal form is always padded to three digits; hex form is two digits and H.
   always_comb begin
      hundreds = value / 8'h64;
      rest = value % 8'h64;
      if (hexMode) begin
         char0 = hexChar(value[7:4]);
         char1 = hexChar(value[3:0]);
         char2 = `CH_H;
      end else begin
         char0 = hundreds + `CH_0;
         char1 = (rest / 8'h0A) + `CH_0;
         char2 = (rest % 8'h0A) + `CH_0;
      end
   end

endmodule

// ==== dv/parameter_register_access_properties.sv ====
// Port checker for the parameter register command interpreter.
// Assumes the terminator register keeps its factory code 8'h0D during the run.
`timescale 1ns/1ps

module parameter_register_access_properties (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Terminal side.
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic nvFactory
);
   logic [7:0] prevChar_r;
   logic [7:0] olderChar_r;
   logic [4:0] sinceEvt_r;
   logic handshake;

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   // A character leaves only when valid and ready meet.
   assign handshake = txValid && txReady;

   function automatic logic hexDigit(input logic [7:0] c);
      return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
   endfunction

   // Last two accepted characters, and cycles since a terminator or handshake.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prevChar_r <= 8'h00;
         olderChar_r <= 8'h00;
         sinceEvt_r <= 5'd0;
      end else begin
         if (handshake) begin
            prevChar_r <= txData;
            olderChar_r <= prevChar_r;
         end
         if (handshake || (rxValid && rxData == 8'h0D)) begin
            sinceEvt_r <= 5'd0;
         end else if (sinceEvt_r != 5'd31) begin
            sinceEvt_r <= sinceEvt_r + 5'd1;
         end
      end
   end

   hold_reply_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("reply character dropped or changed before acceptance");
   // Judged one edge later, since the very first edge still samples power-up unknowns.
   reset_quiet_a: assert property (disable iff (1'b0)
      !arst_n |=> !txValid && txData == 8'h00)
      else $error("reply output active during reset");
   load_quiet_a: assert property ($rose(arst_n) |-> !txValid ##1 !txValid)
      else $error("reply started while profiles were loading");
   answer_time_a: assert property (rxValid && rxData == 8'h0D && !txValid |-> ##[2:4] txValid)
      else $error("no reply soon after the line terminator");
   ok_term_a: assert property (handshake && olderChar_r == 8'h4F && prevChar_r == 8'h4B
      |-> txData == 8'h0D)
      else $error("OK result not followed by the terminator");
   error_term_a: assert property (handshake && olderChar_r == 8'h4F && prevChar_r == 8'h52
      |-> txData == 8'h0D)
      else $error("ERROR result not followed by the terminator");
   hex_suffix_a: assert property (handshake && txData == 8'h48
      |-> hexDigit(prevChar_r) && hexDigit(olderChar_r))
      else $error("hex suffix not preceded by two hex digits");
   // Longest quiet gap is the skip over thirteen non-storable registers in a profile section.
   wake_cause_a: assert property ($rose(txValid) |-> sinceEvt_r <= 5'd15)
      else $error("reply character appeared without a command");

   // Main scenarios reached.
   cover property (handshake && olderChar_r == 8'h4F && prevChar_r == 8'h4B);
   cover property (handshake && olderChar_r == 8'h4F && prevChar_r == 8'h52);
   cover property (handshake && txData == 8'h48);
   cover property (txValid && !txReady ##1 handshake);
endmodule

bind parameter_register_access parameter_register_access_properties
   parameter_register_access_properties_i (.clk(clk), .arst_n(arst_n), .rxData(rxData),
   .rxValid(rxValid), .txData(txData), .txValid(txValid), .txReady(txReady),
   .nvFactory(nvFactory));

// ==== dv/terminal_model.sv ====
// Data terminal model: sends command lines and collects reply characters.
// Assumes the bench calls send and reads the got queue by hierarchy.
`timescale 1ns/1ps

module terminal_model (
   // Clock.
   input wire logic clk,
   // Characters toward the block.
   output logic [7:0] rxData,
   output logic rxValid,
   // Characters from the block.
   input wire logic [7:0] txData,
   input wire logic txValid,
   output logic txReady,
   // High makes the sink stall every other cycle.
   input wire logic slow
);
   logic [7:0] got[$];

   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      txReady = 1'b1;
   end

   // Collect each accepted reply character; sampling sees pre-edge values.
   always @(posedge clk) begin
      if (txValid && txReady) begin
         got.push_back(txData);
      end
   end

   // Ready moves only at the falling edge so the handshake is never ambiguous.
   always @(negedge clk) begin
      txReady <= slow ? ~txReady : 1'b1;
   end

   // One character per pulse, spaced out; the data line is scrambled when idle.
   task automatic send(input string line);
      for (int i = 0; i < line.len(); i++) begin
         @(negedge clk);
         rxData = line[i];
         rxValid = 1'b1;
         @(negedge clk);
         rxValid = 1'b0;
         rxData = ~rxData;
      end
   endtask
endmodule

// ==== dv/tb_top.sv ====
// Testbench for the parameter register command interpreter.
// Assumes the terminal model and the bound checker; keeps its own shadow of all registers.
`timescale 1ns/1ps
`include "param_access_regs.svh"

module tb_top;
   localparam logic [223:0] DEF = `DEF_TABLE;
   localparam logic [27:0] USED = `USED_MASK;
   localparam logic [27:0] STORE = `STORE_MASK;
   localparam logic [27:0] HEX = `HEX_MASK;
   localparam string OK = "OK\015";
   localparam string ERR = "ERROR\015";
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic nvFactory = 1'b1;
   logic slow = 1'b0;
   logic [7:0] rxData;
   logic rxValid;
   logic [7:0] txData;
   logic txValid;
   logic txReady;
   logic [7:0] act[28];
   logic [7:0] prof[2][28];
   int startSel = 0;
   int fails = 0;
   int samplesChecked = 0;

   parameter_register_access parameter_register_access_i (.clk(clk), .arst_n(arst_n),
      .rxData(rxData), .rxValid(rxValid), .txData(txData), .txValid(txValid),
      .txReady(txReady), .nvFactory(nvFactory));
   terminal_model terminal_model_i (.clk(clk), .rxData(rxData), .rxValid(rxValid),
      .txData(txData), .txValid(txValid), .txReady(txReady), .slow(slow));

   // Clock of 100 ns period.
   initial begin
      forever #50 clk = ~clk;
   end

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", samplesChecked, fails);
      if (fails == 0 && samplesChecked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk_reply(input string got, input string exp, input string ctx);
      samplesChecked++;
      if (got != exp) begin
         fails++;
         $display("Error at %0t: wrong reply to %s", $time, ctx);
      end
   endtask

   // Power cycle; the shadow follows the load of factory or selected profile values.
   task automatic power(input logic fac);
      @(negedge clk);
      arst_n = 1'b0;
      nvFactory = fac;
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      nvFactory = 1'b0;
      @(negedge clk);
      for (int i = 0; i < 28; i++) begin
         act[i] = DEF[i*8 +: 8];
         if (fac) begin
            prof[0][i] = act[i];
            prof[1][i] = act[i];
         end else if (STORE[i]) begin
            act[i] = prof[startSel][i];
         end
      end
      if (fac) startSel = 0;
   endtask

   // Sends one line and compares the whole reply, waiting out any trailing characters.
   task automatic cmd(input string body, input string exp);
      string got;
      int n;
      got = "";
      n = 0;
      terminal_model_i.got.delete();
      terminal_model_i.send({"AT", body, "\015"});
      while (terminal_model_i.got.size() < exp.len() && n < 5000) begin
         @(negedge clk);
         n++;
      end
      repeat (6) @(negedge clk);
      foreach (terminal_model_i.got[i]) got = $sformatf("%s%c", got, terminal_model_i.got[i]);
      chk_reply(got, exp, body);
   endtask

   function automatic string rd(input int i);
      return $sformatf("%03d\015OK\015", act[i]);
   endfunction

   function automatic string ent(input int i, input logic [7:0] v);
      string s;
      if (HEX[i]) begin
         s = $sformatf("S%02d:%02h", i, v);
         s = s.toupper();
         return {s, "H "};
      end
      return $sformatf("S%02d:%03d ", i, v);
   endfunction

   function automatic string dump();
      string s = "";
      for (int p = 0; p < 3; p++) begin
         for (int i = 0; i < 28; i++) begin
            if (p == 0 ? USED[i] : STORE[i]) s = {s, ent(i, p == 0 ? act[i] : prof[p-1][i])};
         end
         s = {s, "\015"};
      end
      return {s, OK};
   endfunction

   task automatic t_query();
      int idx[6] = '{0, 2, 3, 14, 18, 22};
      foreach (idx[k]) cmd($sformatf("S%0d?", idx[k]), rd(idx[k]));
      $display("Test query done");
   endtask

   task automatic t_write();
      cmd("S18=55", OK);
      act[18] = 8'd55;
      cmd("S18?", rd(18));
      cmd("S07=7", OK);
      act[7] = 8'd7;
      cmd("S7?", rd(7));
      cmd("S5=255", OK);
      act[5] = 8'd255;
      cmd("S05?", rd(5));
      cmd("S5=256", ERR);
      cmd("S5?", rd(5));
      $display("Test write done");
   endtask

   task automatic t_errors();
      int bad[7] = '{11, 13, 15, 17, 19, 28, 99};
      foreach (bad[k]) begin
         cmd($sformatf("S%0d=1", bad[k]), ERR);
         cmd($sformatf("S%0d?", bad[k]), ERR);
      end
      cmd("S12?", rd(12));
      cmd("", OK);
      cmd("s05=0000001", ERR);
      cmd("s5?", rd(5));
      $display("Test errors done");
   endtask

   // Counting down makes each step clear a bit the previous one set.
   task automatic t_bits();
      for (int d = 3; d >= 0; d--) begin
         cmd($sformatf("&D%0d", d), OK);
         act[21] = (act[21] & 8'hE7) | 8'(d << 3);
         cmd("S21?", rd(21));
      end
      $display("Test bits done");
   endtask

   task automatic t_profiles();
      cmd("S18=120", OK);
      act[18] = 8'd120;
      cmd("S2=50", OK);
      act[2] = 8'd50;
      cmd("&W1", OK);
      for (int i = 0; i < 28; i++) if (STORE[i]) prof[1][i] = act[i];
      cmd("S18=9", OK);
      act[18] = 8'd9;
      cmd("&W0", OK);
      for (int i = 0; i < 28; i++) if (STORE[i]) prof[0][i] = act[i];
      cmd("&Y1", OK);
      startSel = 1;
      power(1'b0);
      cmd("S18?", rd(18));
      cmd("S2?", rd(2));
      cmd("&Y0", OK);
      startSel = 0;
      power(1'b0);
      cmd("S18?", rd(18));
      $display("Test profiles done");
   endtask

   // The sink stalls throughout the long display.
   task automatic t_display();
      slow = 1'b1;
      cmd("&V", dump());
      slow = 1'b0;
      $display("Test display done");
   endtask

   initial begin
      power(1'b1);
      t_query();
      t_write();
      t_errors();
      t_bits();
      t_profiles();
      t_display();
      close_out();
   end

   // Watchdog well beyond the expected run of about 2500 cycles.
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("Error at %0t: watchdog expired", $time);
      close_out();
   end
endmodule
